// ### logic/mac_backoff_duplex_speed_ctrl.sv
// collision back-off, duplex and speed control with a mac reset bit
// assumes a plain register port, synchronous inputs, one 200 MHz clock
//
// Operation
// - collision waits random slot count below 2^K
// - K is min of retry count, ten
// - random value comes from free-running LFSR
// - wait counter loads LFSR bits, counts slots
// - limit field 7:6, 00 ten, 10 four
// - slot time is 512 bit times
// - duplex bit 3 writable unless auto detect
// - full duplex never defers on collision
// - gigabit speed forces full duplex
// - speed field 2:1 writable unless auto detect
// - speeds offered are 10, 100, 1000
// - speed survives protected soft reset, duplex then follows phy duplex
// - auto speed samples receive clock, reports it
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module mac_backoff_duplex_speed_ctrl
    import mac_backoff_pkg::*;
#(
    parameter int SLOT10 = mac_backoff_pkg::SLOT_CYC_10 // 10 Mb/s slot
)(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [11:0] regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdData,
    input  wire logic        collision,
    input  wire logic [4:0]  retryCount,
    input  wire logic        rxClk,
    input  wire logic        phyDuplexFull,
    input  wire logic        liteReset,
    input  wire logic        rstProtect,
    input  wire logic        rx_enable,
    input  wire logic        tx_enable,
    output logic             backoffActive,
    output logic             retryGo,
    output logic             fullDuplexEff,
    output logic      [1:0]  speedSel,
    output logic             macReset
);
    import mac_backoff_pkg::*;

    // control register state
    logic [1:0]  limit_q, limit_d;         // back-off limit select
    logic        duplex_q, duplex_d;       // duplex select
    logic [1:0]  speed_q, speed_d;         // speed select
    logic        autoSpd_q, autoSpd_d;     // auto speed detect
    logic        autoDpx_q, autoDpx_d;     // auto duplex detect
    logic        macReset_q;               // reset pulse
    logic [31:0] rdData_q;                 // read data
    // back-off state
    logic [15:0] lfsr_q;                   // random source
    logic        busy_q;                   // waiting out slots
    logic [9:0]  waitCnt_q;                // slots still to wait
    logic [15:0] slotCnt_q;                // cycles left in slot
    logic        done_q;                   // retry permission
    logic        effFull_q;                // effective full duplex
    // receive clock measurement
    logic        rxc_q;                    // sampled receive clock
    logic [7:0]  rxPer_q;                  // cycles since last edge
    logic [1:0]  detSpd_q;                 // last detected speed

    // register decode
    wire ctrlHit   = (regAddr == CTRL_OFFSET);
    wire statusHit = (regAddr == STATUS_OFFSET);
    wire ctrlWr    = regWr && ctrlHit;
    // writes are taken whenever they come; keeping the mac idle is
    // software's part
    wire idle      = !rx_enable && !tx_enable;

    // read mux, reset bit reads zero
    wire [31:0] ctrlWord = {19'h0, autoDpx_q, autoSpd_q, 3'h0, limit_q,
                            2'h0, duplex_q, speed_q, 1'h0};
    wire [31:0] statWord = {11'h0, idle, detSpd_q, effFull_q, done_q,
                            busy_q, 5'h0, waitCnt_q};
    wire [31:0] rdMux    = ctrlHit ? ctrlWord
                         : statusHit ? statWord : 32'h0;

    // soft reset shield for duplex and speed
    wire softLoad = liteReset && !rstProtect;

    // next values of the control fields
    always_comb begin
        limit_d   = limit_q;
        autoSpd_d = autoSpd_q;
        autoDpx_d = autoDpx_q;
        duplex_d  = duplex_q;
        speed_d   = speed_q;
        if (ctrlWr) begin
            limit_d   = regWrData[LIMIT_LSB +: 2];
            autoSpd_d = regWrData[AUTO_SPD_BIT];
            autoDpx_d = regWrData[AUTO_DPX_BIT];
        end
        // duplex follows phy or software
        if (autoDpx_q) begin
            duplex_d = phyDuplexFull;
        end else if (ctrlWr) begin
            duplex_d = regWrData[DUPLEX_BIT];
        end
        // speed follows detection or software
        if (autoSpd_q) begin
            speed_d = detSpd_q;
        end else if (ctrlWr) begin
            speed_d = regWrData[SPEED_LSB +: 2];
        end
        // lite reset reloads defaults; protected fields kept
        if (liteReset) begin
            limit_d   = LIMIT_RST;
            autoSpd_d = AUTO_SPD_RST;
            autoDpx_d = AUTO_DPX_RST;
        end
        if (softLoad) begin
            duplex_d = DUPLEX_RST;
            speed_d  = SPEED_RST;
        end
    end

    // control registers and read port
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            limit_q    <= LIMIT_RST;
            autoSpd_q  <= AUTO_SPD_RST;
            autoDpx_q  <= AUTO_DPX_RST;
            duplex_q   <= DUPLEX_RST;
            speed_q    <= SPEED_RST;
            macReset_q <= 1'h0;
            rdData_q   <= 32'h0;
            effFull_q  <= 1'h0;
        end else begin
            limit_q    <= limit_d;
            autoSpd_q  <= autoSpd_d;
            autoDpx_q  <= autoDpx_d;
            duplex_q   <= duplex_d;
            speed_q    <= speed_d;
            macReset_q <= ctrlWr && regWrData[RESET_BIT];
            rdData_q   <= regRd ? rdMux : 32'h0;
            effFull_q  <= duplex_q || (speed_q == SPD_1000);
        end
    end

    // receive clock period measure, input already synchronous
    wire rxcRise = rxClk && !rxc_q;
    wire [1:0] perSpd = (rxPer_q <= RXC_GIG_MAX)  ? SPD_1000
                      : (rxPer_q <= RXC_FAST_MAX) ? SPD_100 : SPD_10;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rxc_q    <= 1'h0;
            rxPer_q  <= 8'h0;
            detSpd_q <= SPEED_RST;
        end else begin
            rxc_q    <= rxClk;
            if (rxcRise) begin
                rxPer_q  <= 8'h1;
                detSpd_q <= perSpd;
            end else if (rxPer_q != 8'hFF) begin
                rxPer_q  <= rxPer_q + 8'h1;
            end
        end
    end

    // exponent and limit cap
    wire [3:0] kVal = (retryCount > 5'(K_MAX)) ? K_MAX
                    : retryCount[3:0];
    wire [3:0] cap  = (limit_q == 2'h0) ? CAP_LIM00
                    : (limit_q == 2'h1) ? CAP_LIM01
                    : (limit_q == 2'h2) ? CAP_LIM10
                    : CAP_LIM11;
    wire [3:0] nBits = (kVal < cap) ? kVal : cap;

    // low-bit mask of nBits ones
    logic [9:0] bitMask;
    for (genvar i = 0; i < 10; i++) begin : g_mask
        assign bitMask[i] = (i < int'(nBits));
    end
    wire [9:0] pick = lfsr_q[9:0] & bitMask;

    // slot length at the running speed
    wire [15:0] slotLen = (speed_q == SPD_1000) ? 16'(SLOT_CYC_1000)
                        : (speed_q == SPD_100)  ? 16'(SLOT_CYC_100)
                        : 16'(SLOT10);

    // collision accepted only in half duplex when idle in back-off
    wire takeColl = collision && !effFull_q && !busy_q;
    wire slotEnd  = busy_q && (slotCnt_q == 16'h0);
    wire fb = lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10];

    // lfsr and wait countdown
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lfsr_q <= LFSR_SEED;
        end else begin
            lfsr_q <= {lfsr_q[14:0], fb};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || macReset_q) begin
            busy_q    <= 1'h0;
            waitCnt_q <= 10'h0;
            slotCnt_q <= 16'h0;
            done_q    <= 1'h0;
        end else begin
            done_q <= 1'h0;
            if (takeColl) begin
                // zero draw retries at once
                busy_q    <= (pick != 10'h0);
                done_q    <= (pick == 10'h0);
                waitCnt_q <= pick;
                slotCnt_q <= slotLen - 16'h1;
            end else if (slotEnd) begin
                waitCnt_q <= waitCnt_q - 10'h1;
                slotCnt_q <= slotLen - 16'h1;
                if (waitCnt_q == 10'h1) begin
                    busy_q <= 1'h0;
                    done_q <= 1'h1;
                end
            end else if (busy_q) begin
                slotCnt_q <= slotCnt_q - 16'h1;
            end
        end
    end

    assign regRdData     = rdData_q;
    assign backoffActive = busy_q;
    assign retryGo       = done_q;
    assign fullDuplexEff = effFull_q;
    assign speedSel      = speed_q;
    assign macReset      = macReset_q;

    // step sequences of the mac reset bit
    sequence resetWrite;
        ctrlWr && regWrData[RESET_BIT];
    endsequence
    sequence resetPulse;
        macReset_q ##1 !macReset_q;
    endsequence

    a_reset_selfclear: assert property (@(posedge ref_clk)
        disable iff (!rst_n) resetWrite |=> resetPulse)
        else $error("mac reset bit did not pulse once");
    a_reset_reads_zero: assert property (@(posedge ref_clk)
        disable iff (!rst_n) (regRd && ctrlHit) |=> !regRdData[0])
        else $error("mac reset bit read as one");
    a_load_capped: assert property (@(posedge ref_clk)
        disable iff (!rst_n) (takeColl && !macReset_q) |=>
        (waitCnt_q >> $past(nBits)) == 10'h0)
        else $error("wait count exceeds limit");
    a_k_ceiling: assert property (@(posedge ref_clk)
        disable iff (!rst_n) (retryCount >= 5'hC && limit_q == 2'h0)
        |-> nBits == 4'hA)
        else $error("exponent not capped at ten");
    a_full_no_defer: assert property (@(posedge ref_clk)
        disable iff (!rst_n) (collision && effFull_q && !busy_q)
        |=> !busy_q)
        else $error("full duplex deferred on collision");
    a_gig_full: assert property (@(posedge ref_clk)
        disable iff (!rst_n) (speed_q == SPD_1000) |=> effFull_q)
        else $error("half duplex at gigabit");
    a_slot_step: assert property (@(posedge ref_clk)
        disable iff (!rst_n) (slotEnd && !macReset_q && waitCnt_q > 10'h1)
        |=> busy_q && waitCnt_q == $past(waitCnt_q) - 10'h1)
        else $error("wait count did not step once per slot");
    a_last_slot_go: assert property (@(posedge ref_clk)
        disable iff (!rst_n) (slotEnd && !macReset_q && waitCnt_q == 10'h1)
        |=> done_q ##1 !done_q)
        else $error("retry not released after last slot");
    a_speed_write: assert property (@(posedge ref_clk)
        disable iff (!rst_n) (ctrlWr && !autoSpd_q && !softLoad)
        |=> speed_q == $past(regWrData[2:1]))
        else $error("speed write not taken");
    a_dpx_tracks: assert property (@(posedge ref_clk)
        disable iff (!rst_n) (autoDpx_q && !softLoad)
        |=> duplex_q == $past(phyDuplexFull))
        else $error("duplex does not report detection");
    a_protect_keep: assert property (@(posedge ref_clk)
        disable iff (!rst_n) (liteReset && rstProtect && !ctrlWr
        && !autoSpd_q) |=> speed_q == $past(speed_q))
        else $error("protected speed reloaded");
    // back-off load, release, reset clearing, soft reload and auto speed
    a_zero_draw_go: assert property (@(posedge ref_clk)
        disable iff (!rst_n) (takeColl && !macReset_q && pick == 10'h0)
        |=> retryGo && !backoffActive)
        else $error("zero draw did not retry at once");
    a_draw_loaded: assert property (@(posedge ref_clk)
        disable iff (!rst_n) (takeColl && !macReset_q && pick != 10'h0)
        |=> backoffActive && waitCnt_q == $past(pick))
        else $error("wait counter not loaded with draw");
    a_reset_clears: assert property (@(posedge ref_clk)
        disable iff (!rst_n) macReset_q |=> !busy_q && !done_q)
        else $error("mac reset left back-off running");
    a_soft_reload: assert property (@(posedge ref_clk)
        disable iff (!rst_n) softLoad
        |=> speed_q == SPEED_RST && duplex_q == DUPLEX_RST)
        else $error("unprotected soft reset kept speed or duplex");
    a_auto_speed: assert property (@(posedge ref_clk)
        disable iff (!rst_n) (autoSpd_q && !softLoad)
        |=> speed_q == $past(detSpd_q))
        else $error("speed does not report detection");
endmodule : mac_backoff_duplex_speed_ctrl

// ### logic/mac_backoff_pkg.sv
// constants shared by the back-off, duplex and speed control logic
// assumes a 200 MHz reference clock and a word-wide register port
package mac_backoff_pkg;
    // register map, word addresses on the register port
    localparam logic [11:0] CTRL_OFFSET   = 12'h100; // control word
    localparam logic [11:0] STATUS_OFFSET = 12'h1F0; // live state word
    // control field positions
    localparam int RESET_BIT    = 0;  // self-clearing mac reset
    localparam int SPEED_LSB    = 1;  // speed select, two bits
    localparam int DUPLEX_BIT   = 3;  // duplex select
    localparam int LIMIT_LSB    = 6;  // back-off limit, two bits
    localparam int AUTO_SPD_BIT = 11; // automatic speed detection
    localparam int AUTO_DPX_BIT = 12; // automatic duplex detection
    // reset values
    localparam logic [1:0] LIMIT_RST    = 2'h0;
    localparam logic       DUPLEX_RST   = 1'h0;
    localparam logic [1:0] SPEED_RST    = 2'h0;
    localparam logic       AUTO_SPD_RST = 1'h0;
    localparam logic       AUTO_DPX_RST = 1'h1;
    localparam logic [15:0] LFSR_SEED   = 16'hACE1;
    // speed encodings
    localparam logic [1:0] SPD_10   = 2'h0;
    localparam logic [1:0] SPD_100  = 2'h1;
    localparam logic [1:0] SPD_1000 = 2'h2;
    // back-off exponent ceiling and limit caps
    localparam logic [3:0] K_MAX     = 4'hA;
    localparam logic [3:0] CAP_LIM00 = 4'hA;
    localparam logic [3:0] CAP_LIM01 = 4'h8;
    localparam logic [3:0] CAP_LIM10 = 4'h4;
    localparam logic [3:0] CAP_LIM11 = 4'h1;
    // slot time in bit times and bit times in picoseconds
    localparam longint SLOT_BITS   = 512;
    localparam longint CLK_PS      = 5000;
    localparam longint BIT_PS_10   = 100000;
    localparam longint BIT_PS_100  = 10000;
    localparam longint BIT_PS_1000 = 1000;
    // slot time in clock cycles, a least time so rounded up
    localparam int SLOT_CYC_10   =
        int'((SLOT_BITS * BIT_PS_10 + CLK_PS - 1) / CLK_PS);
    localparam int SLOT_CYC_100  =
        int'((SLOT_BITS * BIT_PS_100 + CLK_PS - 1) / CLK_PS);
    localparam int SLOT_CYC_1000 =
        int'((SLOT_BITS * BIT_PS_1000 + CLK_PS - 1) / CLK_PS);
    // receive clock period thresholds in reference cycles
    localparam logic [7:0] RXC_GIG_MAX  = 8'h04;
    localparam logic [7:0] RXC_FAST_MAX = 8'h14;
endpackage : mac_backoff_pkg

// ### verification/phy_line_model.sv
// line-side phy stand-in: free receive clock and reported duplex
// assumes the bench picks the half period in reference cycles
`timescale 1ns/1ps
module phy_line_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] halfPer,
    input  wire logic       fullIn,
    output logic            rxClk,
    output logic            phyDuplexFull
);
    logic [7:0] cnt_q = 8'h00; // cycles into the current half period
    initial rxClk = 1'b0;
    // receive clock flips every halfPer reference cycles
    always @(posedge ref_clk) begin
        if (cnt_q + 8'h01 >= halfPer) begin
            cnt_q <= 8'h00;
            rxClk <= ~rxClk;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    // duplex as negotiated on the line
    assign phyDuplexFull = fullIn;
endmodule : phy_line_model

// ### verification/mac_backoff_duplex_speed_ctrl_tb.sv
// self-checking bench for back-off, duplex and speed control
// assumes the phy stand-in and a shortened 10 Mb/s slot
`timescale 1ns/1ps
module mac_backoff_duplex_speed_ctrl_tb;
    import mac_backoff_pkg::*;
    localparam int SLOT = 40; // shortened 10 Mb/s slot
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [11:0] regAddr = 12'h000;
    logic [31:0] regWrData = 32'h00000000;
    logic [31:0] regRdData;
    logic [31:0] rdv;
    logic [4:0]  retryCount = 5'h00;
    logic        collision = 1'b0;
    logic        liteReset = 1'b0;
    logic        rstProtect = 1'b0;
    logic        phyFull = 1'b0;
    logic        enOff = 1'b0; // both mac enables kept low
    logic [7:0]  halfPer = 8'h0B;
    logic        rxClk, phyDuplexFull, backoffActive, retryGo;
    logic        fullDuplexEff, macReset;
    logic [1:0]  speedSel;
    int          fails = 0, checks_done = 0, cyc = 0, w, n;
    int          mAs = 0, mAd = 1, mLim = 0, mDup = 0, mSpd = 0;
    int          caps[4] = '{10, 8, 4, 1};
    int          halves[3] = '{2, 10, 11};

    always #2.5 ref_clk = ~ref_clk;

    mac_backoff_duplex_speed_ctrl #(.SLOT10(SLOT)) i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .collision(collision),
        .retryCount(retryCount), .rxClk(rxClk),
        .phyDuplexFull(phyDuplexFull), .liteReset(liteReset),
        .rstProtect(rstProtect), .rx_enable(enOff), .tx_enable(enOff),
        .backoffActive(backoffActive), .retryGo(retryGo),
        .fullDuplexEff(fullDuplexEff), .speedSel(speedSel),
        .macReset(macReset));

    phy_line_model i_phy (.ref_clk(ref_clk), .halfPer(halfPer),
        .fullIn(phyFull), .rxClk(rxClk), .phyDuplexFull(phyDuplexFull));

    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic give_verdict;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    // one-cycle register write
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
        #1;
    endtask : wr

    // one-cycle read, data taken in the following cycle
    task automatic rd(input logic [11:0] a);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        rdv = regRdData;
    endtask : rd

    // model: speed from the receive clock period
    function automatic int spdE();
        int p;
        p = 2 * halfPer;
        if (!mAs) return mSpd;
        return (p <= 4) ? 2 : (p <= 20) ? 1 : 0;
    endfunction : spdE

    function automatic int dupE();
        return mAd ? int'(phyFull) : mDup;
    endfunction : dupE

    function automatic logic [31:0] cw();
        return 32'(mAd << 12 | mAs << 11 | mLim << 6 | dupE() << 3
            | spdE() << 1);
    endfunction : cw

    // write control, then compare word and outputs with the model
    task automatic setc(input int as, ad, lim, dup, spd);
        // a field left by detection keeps the last detected value
        mSpd = mAs ? spdE() : spd;
        mDup = mAd ? dupE() : dup;
        mAs = as;
        mAd = ad;
        mLim = lim;
        wr(CTRL_OFFSET, 32'(ad << 12 | as << 11 | lim << 6 | dup << 3
            | spd << 1));
        repeat (2) @(posedge ref_clk);
        rd(CTRL_OFFSET);
        chk(rdv, cw());
        chk(speedSel, spdE());
        chk(fullDuplexEff, dupE() | (spdE() == 2));
    endtask : setc

    // collision, then measure the wait until retry
    task automatic bo(input logic [4:0] rc, input int slot);
        logic act;
        n = rc > 10 ? 10 : rc;
        n = n < caps[mLim] ? n : caps[mLim];
        @(posedge ref_clk);
        collision <= 1'b1;
        retryCount <= rc;
        @(posedge ref_clk);
        collision <= 1'b0;
        #1;
        act = backoffActive;
        w = 0;
        while (retryGo !== 1'b1 && w < 50000) begin
            @(posedge ref_clk);
            #1;
            w++;
        end
        chk(retryGo, 1'b1);
        chk(act, w > 0);
        chk(w % slot, 0);
        chk(w / slot < (1 << n), 1);
        @(posedge ref_clk);
        #1;
        chk({backoffActive, retryGo}, 0);
    endtask : bo

    // collision in full duplex must be ignored
    task automatic fd();
        @(posedge ref_clk);
        collision <= 1'b1;
        retryCount <= 5'h0C; // also holds the exponent at ten
        @(posedge ref_clk);
        collision <= 1'b0;
        #1;
        chk({backoffActive, retryGo}, 0);
    endtask : fd

    // hang guard
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fails++;
            give_verdict();
        end
    end

    initial begin
        void'($urandom(20));
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(CTRL_OFFSET);
        chk(rdv, 32'h00001000);
        rd(12'h104);
        chk(rdv, 32'h00000000);
        rd(STATUS_OFFSET);
        chk(rdv[20], 1'b1);
        for (int i = 0; i < 8; i++) begin
            setc(0, 0, i % 4, 0, 0);
            bo((i % 4 == 0) ? 5'($urandom % 6) : 5'($urandom), SLOT);
        end
        setc(0, 0, 3, 0, 1);
        repeat (2) bo(5'h07, 512 * 10 / 5);
        // self-clearing mac reset
        wr(CTRL_OFFSET, cw() | 32'h00000001);
        chk(macReset, 1'b1);
        @(posedge ref_clk);
        #1;
        chk(macReset, 1'b0);
        rd(CTRL_OFFSET);
        chk(rdv, cw());
        setc(0, 0, 0, 0, 2);
        fd();
        setc(0, 0, 0, 1, 0);
        fd();
        // automatic speed at the period boundaries
        foreach (halves[j]) begin
            @(posedge ref_clk) halfPer <= 8'(halves[j]);
            repeat (100) @(posedge ref_clk);
            setc(1, 0, 0, 0, 3);
        end
        // soft reset with and without protection
        @(posedge ref_clk) phyFull <= 1'b1;
        setc(0, 0, 2, 1, 1);
        setc(0, 0, 2, 1, 1);
        for (int p = 1; p >= 0; p--) begin
            @(posedge ref_clk);
            rstProtect <= p[0];
            liteReset <= 1'b1;
            @(posedge ref_clk);
            liteReset <= 1'b0;
            mLim = 0;
            mAs = 0;
            mAd = 1;
            if (p == 0) mSpd = 0;
            rd(CTRL_OFFSET);
            chk(rdv, cw());
            chk(speedSel, spdE());
        end
        give_verdict();
    end
endmodule : mac_backoff_duplex_speed_ctrl_tb
